/* tcr_pkg.sv */
// tcr_pkg: constants and types for the capture/reload timer block
// assumes an apb master with 32-bit data; registers sit in the low byte
package tcr_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CTL = 8'hC8;
    localparam logic [7:0] IDX_MODE = 8'hC9;
    localparam logic [7:0] IDX_RCL = 8'hCA;
    localparam logic [7:0] IDX_RCH = 8'hCB;
    localparam logic [7:0] IDX_CNTL = 8'hCC;
    localparam logic [7:0] IDX_CNTH = 8'hCD;
    localparam logic [7:0] IDX_CFG = 8'hCE;
    localparam logic [7:0] IDX_EVST = 8'hCF;
    localparam logic [7:0] IDX_EVMSK = 8'hD0;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTL_OVF = 7;
    localparam int CTL_EXT = 6;
    localparam int CTL_RXB = 5;
    localparam int CTL_TXB = 4;
    localparam int CTL_TEN = 3;
    localparam int CTL_RUN = 2;
    localparam int CTL_CT = 1;
    localparam int CTL_CP = 0;
    localparam int MODE_CRE = 3;
    localparam int MODE_DOWN_COUNT_ENABLE = 0;
    localparam int CFG_IRQEN = 0;
    localparam int CFG_FAST = 1;
    localparam int EV_OVF = 0;
    localparam int EV_TRIG = 1;
    localparam int EV_CAP = 2;
    localparam int EV_RLD = 3;
    localparam int EV_W = 4;

    // ------------------------------------------------------------
    // writable masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_MASK = 8'h09;
    localparam logic [7:0] CFG_MASK = 8'h03;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_TOP = 16'hFFFF;

    // ------------------------------------------------------------
    // timing: clocks per count step
    // ------------------------------------------------------------
    localparam logic [3:0] TICK_SLOW = 4'hC;
    localparam logic [3:0] TICK_FAST = 4'h4;
    localparam logic [3:0] TICK_BAUD = 4'h2;

    typedef struct packed {
        logic rx;
        logic tx;
    } tcr_baud_t;

    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] mode;
        logic [7:0] cfg;
        logic [15:0] rcap;
        logic [15:0] cnt;
        logic [EV_W-1:0] evst;
        logic [EV_W-1:0] evmsk;
        logic [3:0] pre;
        logic trig_prev;
        logic cin_prev;
        logic [7:0] rd;
        logic ready;
        logic slverr;
        logic timer_irq;
        logic event_irq;
        tcr_baud_t baud;
    } tcr_state_t;

endpackage

/* tcr_timer.sv */
// tcr_timer: 16-bit capture/reload/baud timer with an apb register port
// assumes trigger_pin, count_input_pin and timer1_ovf are synchronous to pclk
`timescale 1ns/1ps

// Behaviour
// - overflow flag sets on overflow, and on count equal reload when counting down
// - hardware sets overflow flag only outside baud mode; software may set/clear
// - external flag sets on trigger falling edge or overflow per mode bits
// - external flag stays until cleared; software set also raises interrupt
// - receive baud select picks timer 1 overflow or this timer's overflow
// - transmit baud select picks timer 1 overflow or this timer's overflow
// - either baud select forces auto-reload baud mode, ignoring capture select
// - baud mode advances once every 2 clocks whatever counter select says
// - trigger ignored when disabled; else falling edge captures or reloads
// - clearing run stops counting and holds both count bytes
// - counter select zero counts clocks at fast- or slow-tick rate per config; one counts pin edges
// - reload mode reloads on overflow, and on trigger edge when enabled and running
// - capture mode copies count bytes into capture registers on trigger edge
// - capture-reset enable clears the counter right after a capture while running
// - down-count enable with trigger level sets direction in reload mode
// - capture registers hold captured count or the 16-bit reload value
// - timer interrupt raised only when timer interrupt enable is set
module tcr_timer #(
    parameter int unsigned ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trigger_pin,
    input wire logic count_input_pin,
    input wire logic timer1_ovf,
    output logic timer_irq,
    output logic event_irq,
    output tcr_pkg::tcr_baud_t baud_tick
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (ADDR_W < 10) begin : g_chk
        $error("tcr_timer: ADDR_W below 10 cannot reach the register indices");
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic map_hit(input logic [ADDR_W-1:0] a);
        logic [7:0] i;
        i = a[9:2];
        map_hit = (a[1:0] == 2'h0) && ((a >> 10) == '0) &&
            (i >= tcr_pkg::IDX_CTL) && (i <= tcr_pkg::IDX_EVMSK);
    endfunction

    function automatic logic [7:0] map_idx(input logic [ADDR_W-1:0] a);
        map_idx = a[9:2];
    endfunction

    tcr_pkg::tcr_state_t s_q;
    tcr_pkg::tcr_state_t s_d;

    logic acc;
    logic wr;
    logic [7:0] widx;
    logic [7:0] wb;
    logic baud;
    logic run;
    logic down_count_enable;
    logic cap_mode;
    logic down;
    logic fall_trig;
    logic fall_cin;
    logic tick;
    logic adv;
    logic ovf_up;
    logic udf;
    logic ovf_evt;
    logic trig_act;
    logic trig_rld;
    logic ovf_rld;
    logic [3:0] period;

    localparam int EV_W_L = tcr_pkg::EV_W;

    logic [EV_W_L-1:0] ev;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        acc = psel && penable && s_q.ready;
        wr = acc && pwrite && pstrb[0] && map_hit(paddr);
        widx = map_idx(paddr);
        wb = pwdata[7:0];

        baud = s_q.ctl[tcr_pkg::CTL_RXB] || s_q.ctl[tcr_pkg::CTL_TXB];
        run = s_q.ctl[tcr_pkg::CTL_RUN];
        down_count_enable = s_q.mode[tcr_pkg::MODE_DOWN_COUNT_ENABLE];
        cap_mode = s_q.ctl[tcr_pkg::CTL_CP] && !baud;
        // direction only matters in plain auto-reload mode
        down = !baud && !cap_mode && down_count_enable && !trigger_pin;
        fall_trig = s_q.trig_prev && !trigger_pin;
        fall_cin = s_q.cin_prev && !count_input_pin;

        // prescaler: only runs while the timer runs; a stop clears it to zero
        if (baud) begin
            period = tcr_pkg::TICK_BAUD;
        end else if (s_q.cfg[tcr_pkg::CFG_FAST]) begin
            period = tcr_pkg::TICK_FAST;
        end else begin
            period = tcr_pkg::TICK_SLOW;
        end
        tick = run && (s_q.pre == 4'h0);
        if (!run) begin
            s_d.pre = 4'h0;
        end else if (tick) begin
            s_d.pre = 4'(period - 4'h1);
        end else begin
            s_d.pre = 4'(s_q.pre - 4'h1);
        end

        adv = run && ((baud || !s_q.ctl[tcr_pkg::CTL_CT]) ? tick : fall_cin);
        ovf_up = adv && !down && (s_q.cnt == tcr_pkg::CNT_TOP);
        udf = adv && down && (s_q.cnt == s_q.rcap);
        ovf_evt = ovf_up || udf;
        ovf_rld = ovf_up && !cap_mode;
        // with down counting active the pin steers direction, not reload
        trig_act = s_q.ctl[tcr_pkg::CTL_TEN] && !baud && fall_trig &&
            !(down_count_enable && !cap_mode);
        trig_rld = trig_act && !cap_mode && run;

        // counter
        if (adv) begin
            if (down) begin
                s_d.cnt = udf ? tcr_pkg::CNT_TOP : 16'(s_q.cnt - 16'h0001);
            end else if (ovf_up) begin
                s_d.cnt = cap_mode ? tcr_pkg::CNT_RST : s_q.rcap;
            end else begin
                s_d.cnt = 16'(s_q.cnt + 16'h0001);
            end
        end
        if (trig_rld) begin
            s_d.cnt = s_q.rcap;
        end
        if (trig_act && cap_mode) begin
            s_d.rcap = s_q.cnt;
            if (s_q.mode[tcr_pkg::MODE_CRE] && run) begin
                s_d.cnt = tcr_pkg::CNT_RST;
            end
        end

        // software writes win over hardware on data bytes
        if (wr) begin
            unique case (widx)
                tcr_pkg::IDX_CTL: s_d.ctl = wb;
                tcr_pkg::IDX_MODE: s_d.mode = wb & tcr_pkg::MODE_MASK;
                tcr_pkg::IDX_RCL: s_d.rcap[7:0] = wb;
                tcr_pkg::IDX_RCH: s_d.rcap[15:8] = wb;
                tcr_pkg::IDX_CNTL: s_d.cnt[7:0] = wb;
                tcr_pkg::IDX_CNTH: s_d.cnt[15:8] = wb;
                tcr_pkg::IDX_CFG: s_d.cfg = wb & tcr_pkg::CFG_MASK;
                tcr_pkg::IDX_EVST: s_d.evst = s_q.evst & ~wb[EV_W_L-1:0];
                tcr_pkg::IDX_EVMSK: s_d.evmsk = wb[EV_W_L-1:0];
                default: ;
            endcase
        end

        // hardware sets win over a same-cycle software clear
        if (ovf_evt && !baud) begin
            s_d.ctl[tcr_pkg::CTL_OVF] = 1'b1;
        end
        if (trig_act || (udf && down_count_enable) || (ovf_up && down_count_enable && !cap_mode && !baud)) begin
            s_d.ctl[tcr_pkg::CTL_EXT] = 1'b1;
        end

        ev = '0;
        ev[tcr_pkg::EV_OVF] = ovf_evt;
        ev[tcr_pkg::EV_TRIG] = trig_act;
        ev[tcr_pkg::EV_CAP] = trig_act && cap_mode;
        ev[tcr_pkg::EV_RLD] = ovf_rld || trig_rld;
        s_d.evst = s_d.evst | ev;

        // baud time-bases; the overflow pulse leaves one cycle later
        s_d.baud.rx = s_q.ctl[tcr_pkg::CTL_RXB] ? (ovf_up && baud) : timer1_ovf;
        s_d.baud.tx = s_q.ctl[tcr_pkg::CTL_TXB] ? (ovf_up && baud) : timer1_ovf;

        s_d.timer_irq = s_d.cfg[tcr_pkg::CFG_IRQEN] &&
            (s_d.ctl[tcr_pkg::CTL_OVF] || s_d.ctl[tcr_pkg::CTL_EXT]);
        s_d.event_irq = |(s_d.evst & s_d.evmsk);

        s_d.trig_prev = trigger_pin;
        s_d.cin_prev = count_input_pin;

        // apb: read data is sampled in the setup cycle, zero wait states
        s_d.ready = psel && !penable;
        s_d.slverr = psel && !penable && !map_hit(paddr);
        s_d.rd = 8'h00;
        if (psel && !penable && map_hit(paddr)) begin
            unique case (widx)
                tcr_pkg::IDX_CTL: s_d.rd = s_q.ctl;
                tcr_pkg::IDX_MODE: s_d.rd = s_q.mode;
                tcr_pkg::IDX_RCL: s_d.rd = s_q.rcap[7:0];
                tcr_pkg::IDX_RCH: s_d.rd = s_q.rcap[15:8];
                tcr_pkg::IDX_CNTL: s_d.rd = s_q.cnt[7:0];
                tcr_pkg::IDX_CNTH: s_d.rd = s_q.cnt[15:8];
                tcr_pkg::IDX_CFG: s_d.rd = s_q.cfg;
                tcr_pkg::IDX_EVST: s_d.rd = {4'h0, s_q.evst};
                tcr_pkg::IDX_EVMSK: s_d.rd = {4'h0, s_q.evmsk};
                default: s_d.rd = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.ctl <= tcr_pkg::CTL_RST;
            s_q.mode <= tcr_pkg::MODE_RST;
            s_q.cfg <= tcr_pkg::CFG_RST;
            s_q.cnt <= tcr_pkg::CNT_RST;
            s_q.trig_prev <= 1'b1;
            s_q.cin_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = {24'h000000, s_q.rd};
    assign pready = s_q.ready;
    assign pslverr = s_q.slverr;
    assign timer_irq = s_q.timer_irq;
    assign event_irq = s_q.event_irq;
    assign baud_tick = s_q.baud;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_NO_HW_OVF_IN_BAUD: assert property (
        baud && !wr |=> !$rose(s_q.ctl[tcr_pkg::CTL_OVF]))
        else $error("overflow flag set by hardware in baud mode");

    AST_OVF_SETS_FLAG: assert property (
        ovf_evt && !baud |=> s_q.ctl[tcr_pkg::CTL_OVF])
        else $error("overflow did not set the overflow flag");

    AST_EXT_ON_EDGE: assert property (
        trig_act |=> s_q.ctl[tcr_pkg::CTL_EXT] ##1 s_q.timer_irq == s_q.cfg[tcr_pkg::CFG_IRQEN]
        || !$stable(s_q.ctl) || !$stable(s_q.cfg))
        else $error("trigger edge did not set the external flag");

    AST_STOP_HOLDS: assert property (
        !run && !wr |=> $stable(s_q.cnt))
        else $error("count moved while stopped");

    // a count write the cycle before can be followed by a real tick, so skip it
    AST_BAUD_TWO_CLK: assert property (
        baud && run && !wr && !$past(wr) && $changed(s_q.cnt) |=> !$changed(s_q.cnt) || wr)
        else $error("baud mode advanced on two consecutive clocks");

    AST_CAPTURE: assert property (
        trig_act && cap_mode && !wr |=> s_q.rcap == $past(s_q.cnt))
        else $error("capture registers missed the count");

    AST_CAP_RESET: assert property (
        trig_act && cap_mode && run && s_q.mode[tcr_pkg::MODE_CRE] && !wr
        |=> s_q.cnt == tcr_pkg::CNT_RST)
        else $error("counter not cleared after capture");

    AST_RELOAD_OVF: assert property (
        ovf_up && !cap_mode && !trig_act && !wr |=> s_q.cnt == $past(s_q.rcap))
        else $error("overflow did not reload the counter");

    AST_DOWN_STEP: assert property (
        adv && down && !udf && !wr |=> s_q.cnt == 16'($past(s_q.cnt) - 16'h0001))
        else $error("down count step wrong");

    AST_RX_SELECT: assert property (
        !s_q.ctl[tcr_pkg::CTL_RXB] && !$changed(s_q.ctl) ##0 timer1_ovf
        |=> s_q.baud.rx)
        else $error("receive time-base not taken from timer 1");

    AST_IRQ_GATED: assert property (
        !s_q.cfg[tcr_pkg::CFG_IRQEN] |-> !s_q.timer_irq)
        else $error("timer interrupt raised while disabled");

    // ------------------------------------------------------------
    // counter path, flag and time-base assertions
    // ------------------------------------------------------------
    AST_BAUD_NO_CAPTURE: assert property (
        baud && !wr |=> $stable(s_q.rcap))
        else $error("capture register moved in baud mode");

    AST_TRIG_DISABLED: assert property (
        !s_q.ctl[tcr_pkg::CTL_TEN] && !wr |=> $stable(s_q.rcap))
        else $error("capture register moved with trigger disabled");

    // a match at the reload value wraps the count to all ones
    AST_UDF_LOADS_TOP: assert property (
        udf && !wr |=> s_q.cnt == tcr_pkg::CNT_TOP)
        else $error("down count match did not load all ones");

    AST_UDF_FLAGS: assert property (
        udf |=> s_q.ctl[tcr_pkg::CTL_OVF] && s_q.ctl[tcr_pkg::CTL_EXT])
        else $error("down count match did not set both flags");

    AST_UP_STEP: assert property (
        adv && !down && !ovf_up && !trig_act && !wr
        |=> s_q.cnt == 16'($past(s_q.cnt) + 16'h0001))
        else $error("up count step wrong");

    AST_CAP_WRAP: assert property (
        ovf_up && cap_mode && !trig_act && !wr |=> s_q.cnt == tcr_pkg::CNT_RST)
        else $error("capture mode overflow did not wrap to zero");

    AST_TRIG_RELOAD: assert property (
        trig_rld && !wr |=> s_q.cnt == $past(s_q.rcap))
        else $error("trigger edge did not reload the counter");

    AST_BAUD_RELOAD: assert property (
        baud && ovf_up && !wr |=> s_q.cnt == $past(s_q.rcap))
        else $error("baud mode overflow did not reload the counter");

    AST_RX_OWN: assert property (
        s_q.ctl[tcr_pkg::CTL_RXB] && ovf_up |=> s_q.baud.rx)
        else $error("receive time-base missed this timer's overflow");

    AST_TX_OWN: assert property (
        s_q.ctl[tcr_pkg::CTL_TXB] && ovf_up |=> s_q.baud.tx)
        else $error("transmit time-base missed this timer's overflow");

    AST_TX_SELECT: assert property (
        !s_q.ctl[tcr_pkg::CTL_TXB] && timer1_ovf |=> s_q.baud.tx)
        else $error("transmit time-base not taken from timer 1");

    // only software may clear either flag
    AST_EXT_STICKY: assert property (
        s_q.ctl[tcr_pkg::CTL_EXT] && !wr |=> s_q.ctl[tcr_pkg::CTL_EXT])
        else $error("external flag cleared by hardware");

    AST_OVF_STICKY: assert property (
        s_q.ctl[tcr_pkg::CTL_OVF] && !wr |=> s_q.ctl[tcr_pkg::CTL_OVF])
        else $error("overflow flag cleared by hardware");

    AST_IRQ_RAISED: assert property (
        s_q.cfg[tcr_pkg::CFG_IRQEN] && s_q.ctl[tcr_pkg::CTL_EXT] |-> s_q.timer_irq)
        else $error("external flag did not raise the timer interrupt");

    // prescaler ticks must not leak into pin counting
    AST_PIN_COUNT_ONLY: assert property (
        run && !baud && s_q.ctl[tcr_pkg::CTL_CT] && !fall_cin && !trig_act && !wr
        |=> $stable(s_q.cnt))
        else $error("counter moved without a count pin edge");

endmodule

/* tcr_pins.sv */
// tcr_pins: far-side model of the trigger pin, count input pin and timer 1 overflow
// assumes one bench process calls its tasks; pins move only after a rising pclk edge
`timescale 1ns/1ps
module tcr_pins (
    input wire logic pclk,
    output logic trigger_pin,
    output logic count_input_pin,
    output logic timer1_ovf
);
    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    // idle high, so the edge detectors see no edge straight out of reset
    initial begin
        trigger_pin = 1'b1;
        count_input_pin = 1'b1;
        timer1_ovf = 1'b0;
    end
    // level doubles as count direction while down counting
    task automatic set_trig(input logic lvl);
        @(posedge pclk);
        trigger_pin <= lvl;
    endtask
    // low for two samples so the falling edge cannot be missed
    task automatic fall_trig();
        set_trig(1'b0);
        repeat (2) @(posedge pclk);
        trigger_pin <= 1'b1;
    endtask
    task automatic count_edges(input int n);
        repeat (n) begin
            @(posedge pclk);
            count_input_pin <= 1'b0;
            repeat (2) @(posedge pclk);
            count_input_pin <= 1'b1;
            @(posedge pclk);
        end
    endtask
    task automatic t1_pulses(input int n);
        repeat (n) begin
            @(posedge pclk);
            timer1_ovf <= 1'b1;
            @(posedge pclk);
            timer1_ovf <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask
endmodule

/* test_timer2_capture_reload.sv */
// test_timer2_capture_reload: apb register bench for the capture/reload timer
// assumes tcr_pkg and tcr_pins are compiled first; index n sits at byte 4*n
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
    end \
end
module test_timer2_capture_reload;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic trigger_pin, count_input_pin, timer1_ovf, timer_irq, event_irq;
    tcr_pkg::tcr_baud_t baud_tick;
    logic [7:0] v, w;
    int mismatches = 0;
    int comparisons = 0;
    int rx_n = 0;
    int tx_n = 0;
    tcr_timer #(.ADDR_W(12)) tcr_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigger_pin(trigger_pin),
        .count_input_pin(count_input_pin), .timer1_ovf(timer1_ovf), .timer_irq(timer_irq),
        .event_irq(event_irq), .baud_tick(baud_tick));
    tcr_pins tcr_pins_inst (.pclk(pclk), .trigger_pin(trigger_pin),
        .count_input_pin(count_input_pin), .timer1_ovf(timer1_ovf));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // time-bases are pulses, so they are counted on every rising edge
    always @(posedge pclk) begin
        if (baud_tick.rx === 1'b1) rx_n++;
        if (baud_tick.tx === 1'b1) tx_n++;
    end
    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic apb(input logic wr_en, input logic [7:0] idx, input logic [7:0] wd,
            input logic [3:0] strb, output logic [7:0] rd_v);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        // no local limit: only the watchdog ends a wait for the slave
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_v = prdata[7:0];
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        apb(1'b1, idx, d, 4'h1, x);
    endtask
    task automatic rd(input logic [7:0] idx);
        apb(1'b0, idx, 8'h00, 4'h0, v);
    endtask
    task automatic wcnt(input logic [15:0] c);
        wr(tcr_pkg::IDX_CNTL, c[7:0]);
        wr(tcr_pkg::IDX_CNTH, c[15:8]);
    endtask
    task automatic wrc(input logic [15:0] c);
        wr(tcr_pkg::IDX_RCL, c[7:0]);
        wr(tcr_pkg::IDX_RCH, c[15:8]);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // whole run is under 600 cycles; over thirty times that means a hang
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        wrap_up();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            rd(tcr_pkg::IDX_CTL + 8'(i));
            `CHK(v, 8'h00)
        end
        rd(8'hD4);
        `CHK(last_err, 1'b1)
        apb(1'b1, tcr_pkg::IDX_CNTL, 8'h55, 4'h0, w);
        rd(tcr_pkg::IDX_CNTL);
        `CHK(v, 8'h00)
        // overflow reloads from the capture pair; stopping freezes the count
        wcnt(16'hFFFE);
        wrc(16'h1234);
        wr(tcr_pkg::IDX_CFG, 8'h02);
        wr(tcr_pkg::IDX_CTL, 8'h04);
        repeat (12) @(posedge pclk);
        rd(tcr_pkg::IDX_CTL);
        `CHK(v, 8'h84)
        wr(tcr_pkg::IDX_CTL, 8'h80);
        rd(tcr_pkg::IDX_CNTH);
        `CHK(v, 8'h12)
        rd(tcr_pkg::IDX_CNTL);
        w = v;
        repeat (20) @(posedge pclk);
        rd(tcr_pkg::IDX_CNTL);
        `CHK(v, w)
        `CHK(timer_irq, 1'b0)
        wr(tcr_pkg::IDX_CFG, 8'h03);
        repeat (2) @(posedge pclk);
        `CHK(timer_irq, 1'b1)
        wr(tcr_pkg::IDX_CTL, 8'h00);
        repeat (2) @(posedge pclk);
        `CHK(timer_irq, 1'b0)
        wr(tcr_pkg::IDX_CTL, 8'h40);
        repeat (2) @(posedge pclk);
        `CHK(timer_irq, 1'b1)
        rd(tcr_pkg::IDX_EVST);
        `CHK(v[0], 1'b1)
        `CHK(event_irq, 1'b0)
        wr(tcr_pkg::IDX_EVMSK, 8'h01);
        repeat (2) @(posedge pclk);
        `CHK(event_irq, 1'b1)
        wr(tcr_pkg::IDX_EVST, 8'h0F);
        repeat (2) @(posedge pclk);
        `CHK(event_irq, 1'b0)
        // capture while stopped, then capture with counter clear
        wcnt(16'hABCD);
        wr(tcr_pkg::IDX_CTL, 8'h09);
        tcr_pins_inst.fall_trig();
        repeat (2) @(posedge pclk);
        rd(tcr_pkg::IDX_RCL);
        `CHK(v, 8'hCD)
        rd(tcr_pkg::IDX_RCH);
        `CHK(v, 8'hAB)
        rd(tcr_pkg::IDX_CTL);
        `CHK(v, 8'h49)
        wr(tcr_pkg::IDX_MODE, 8'h08);
        wcnt(16'h5600);
        wr(tcr_pkg::IDX_CTL, 8'h0D);
        tcr_pins_inst.fall_trig();
        wr(tcr_pkg::IDX_CTL, 8'h09);
        rd(tcr_pkg::IDX_CNTH);
        `CHK(v, 8'h00)
        rd(tcr_pkg::IDX_RCH);
        `CHK(v, 8'h56)
        wr(tcr_pkg::IDX_CTL, 8'h01);
        tcr_pins_inst.fall_trig();
        repeat (2) @(posedge pclk);
        rd(tcr_pkg::IDX_RCH);
        `CHK(v, 8'h56)
        // external counting of pin edges
        wr(tcr_pkg::IDX_MODE, 8'h00);
        wcnt(16'h0000);
        wr(tcr_pkg::IDX_CTL, 8'h06);
        tcr_pins_inst.count_edges(5);
        wr(tcr_pkg::IDX_CTL, 8'h00);
        rd(tcr_pkg::IDX_CNTL);
        `CHK(v, 8'h05)
        // reload mode: a trigger edge reloads and sets the external flag
        wrc(16'h3344);
        wr(tcr_pkg::IDX_CTL, 8'h0C);
        tcr_pins_inst.fall_trig();
        rd(tcr_pkg::IDX_CTL);
        `CHK(v, 8'h4C)
        wr(tcr_pkg::IDX_CTL, 8'h00);
        rd(tcr_pkg::IDX_CNTH);
        `CHK(v, 8'h33)
        // direction follows the trigger level when down counting
        wr(tcr_pkg::IDX_MODE, 8'h01);
        wrc(16'h0000);
        wcnt(16'h0010);
        tcr_pins_inst.set_trig(1'b0);
        wr(tcr_pkg::IDX_CTL, 8'h04);
        repeat (16) @(posedge pclk);
        wr(tcr_pkg::IDX_CTL, 8'h00);
        rd(tcr_pkg::IDX_CNTL);
        `CHK(v < 8'h10 && v > 8'h08, 1'b1)
        w = v;
        tcr_pins_inst.set_trig(1'b1);
        wr(tcr_pkg::IDX_CTL, 8'h04);
        repeat (16) @(posedge pclk);
        wr(tcr_pkg::IDX_CTL, 8'h00);
        rd(tcr_pkg::IDX_CNTL);
        `CHK(v > w, 1'b1)
        // down count reaching the reload value sets both flags and wraps
        wcnt(16'h0010);
        wrc(16'h000E);
        tcr_pins_inst.set_trig(1'b0);
        wr(tcr_pkg::IDX_CTL, 8'h04);
        repeat (16) @(posedge pclk);
        rd(tcr_pkg::IDX_CTL);
        `CHK(v, 8'hC4)
        wr(tcr_pkg::IDX_CTL, 8'h00);
        rd(tcr_pkg::IDX_CNTH);
        `CHK(v, 8'hFF)
        // baud mode: capture and counter selects set on purpose, both ignored
        wr(tcr_pkg::IDX_MODE, 8'h00);
        wrc(16'hFFFE);
        for (int i = 0; i < 2; i++) begin
            wcnt(16'hFFFE);
            rx_n = 0;
            tx_n = 0;
            wr(tcr_pkg::IDX_CTL, i ? 8'h17 : 8'h27);
            tcr_pins_inst.t1_pulses(3);
            repeat (68) @(posedge pclk);
            rd(tcr_pkg::IDX_CTL);
            `CHK(v, i ? 8'h17 : 8'h27)
            wr(tcr_pkg::IDX_CTL, 8'h00);
            `CHK((i ? rx_n : tx_n) == 3, 1'b1)
            `CHK((i ? tx_n : rx_n) inside {[19:23]}, 1'b1)
        end
        wrap_up();
    end
endmodule
